// ===== hdl/airg_regs.vh
`ifndef AIRG_REGS_VH
`define AIRG_REGS_VH

// Card-local register offsets within the eight-byte window
`define AIRG_OFS_COMM 3'h4
`define AIRG_OFS_CFG 3'h5

// Reset values
`define AIRG_COMM_RST 8'h00
`define AIRG_CFG_RST 8'h00

// Configuration register fields
`define AIRG_CFG_SRC_LO 4
`define AIRG_CFG_SRC_HI 5

// Interrupt source encodings of {hi, lo}
`define AIRG_SRC_NONE 2'h0
`define AIRG_SRC_TC 2'h1
`define AIRG_SRC_TEST 2'h2
`define AIRG_SRC_SCC 2'h3

// Communications register fields
`define AIRG_COMM_RECEIVE_LINE_ENABLE_BIT 0

// Host interrupt levels and DMA channels served
`define AIRG_NUM_LOW_IRQ 6
`define AIRG_NUM_HIGH_IRQ 5
`define AIRG_NUM_IRQ 11
`define AIRG_NUM_DMA 3

// DMA channel select encodings
`define AIRG_DMA_NONE 2'h0

`endif

// ===== hdl/airg_irq_source.v
`timescale 1ns/1ps
`include "airg_regs.vh"

module airg_irq_source (
	input wire ref_clk,
	input wire rst,
	input wire [1:0] src_sel,
	input wire irq_share_select,
	input wire dma_tc,
	input wire scc_irq,
	input wire tc_clear,
	output reg src_req_r
);

	reg tc_prev_r;
	reg tc_pend_r;
	reg tc_pend_nxt;
	reg src_req_nxt;

	// Terminal count is a pulse, so it is held until software acknowledges
	always @* begin
		tc_pend_nxt = tc_pend_r;
		if (tc_clear)
			tc_pend_nxt = 1'b0;
		if (dma_tc && !tc_prev_r && src_sel == `AIRG_SRC_TC)
			tc_pend_nxt = 1'b1;
	end

	always @* begin
		src_req_nxt = 1'b0;
		case (src_sel)
		`AIRG_SRC_TC: src_req_nxt = tc_pend_r & irq_share_select;
		`AIRG_SRC_TEST: src_req_nxt = 1'b1;
		`AIRG_SRC_SCC: src_req_nxt = scc_irq;
		default: src_req_nxt = 1'b0;
		endcase
	end

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			tc_prev_r <= 1'b0;
			tc_pend_r <= 1'b0;
			src_req_r <= 1'b0;
		end else begin
			tc_prev_r <= dma_tc;
			tc_pend_r <= tc_pend_nxt;
			src_req_r <= src_req_nxt;
		end
	end

endmodule // airg_irq_source

// ===== hdl/airg_dma_route.v
`timescale 1ns/1ps
`include "airg_regs.vh"

module airg_dma_route (
	input wire ref_clk,
	input wire rst,
	input wire [1:0] tx_dma_channel_select,
	input wire [1:0] rx_dma_channel_select,
	input wire tx_req,
	input wire rx_req,
	input wire [2:0] dack_n,
	output reg [2:0] drq_out,
	output reg [2:0] drq_oe_n,
	output reg tx_ack_r,
	output reg rx_ack_r
);

	reg tx_ack_nxt;
	reg rx_ack_nxt;
	integer k;

	// Transmit wins a channel that both paths select; such a setup is illegal anyway
	genvar ch;
	generate
		for (ch = 0; ch < `AIRG_NUM_DMA; ch = ch + 1) begin : g_ch
			wire tx_hit = (tx_dma_channel_select == ch + 1);
			wire rx_hit = (rx_dma_channel_select == ch + 1) && !tx_hit;
			always @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					drq_out[ch] <= 1'b0;
					drq_oe_n[ch] <= 1'b1;
				end else begin
					drq_out[ch] <= (tx_hit & tx_req) | (rx_hit & rx_req);
					drq_oe_n[ch] <= !(tx_hit | rx_hit);
				end
			end
		end
	endgenerate

	always @* begin
		tx_ack_nxt = 1'b0;
		rx_ack_nxt = 1'b0;
		for (k = 0; k < `AIRG_NUM_DMA; k = k + 1) begin
			if (tx_dma_channel_select == k + 1 && !dack_n[k])
				tx_ack_nxt = 1'b1;
			if (rx_dma_channel_select == k + 1 && tx_dma_channel_select != k + 1 && !dack_n[k])
				rx_ack_nxt = 1'b1;
		end
	end

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			tx_ack_r <= 1'b0;
			rx_ack_r <= 1'b0;
		end else begin
			tx_ack_r <= tx_ack_nxt;
			rx_ack_r <= rx_ack_nxt;
		end
	end

endmodule // airg_dma_route

// ===== hdl/airg_glue.v
`timescale 1ns/1ps
`include "airg_regs.vh"

module airg_glue (
	input wire ref_clk,
	input wire rst,
	input wire io_cs,
	input wire [2:0] io_addr,
	input wire io_wr,
	input wire io_rd,
	input wire [7:0] io_wdata,
	output reg [7:0] io_rdata_r,
	output reg io_rvalid_r,
	input wire irq_share_select,
	input wire [5:0] low_irq_level_select,
	input wire [4:0] high_irq_level_select,
	output reg [10:0] irq_out_r,
	output reg [10:0] irq_oe_n_r,
	input wire dma_tc,
	input wire scc_irq,
	input wire tx_req,
	input wire rx_req,
	input wire [1:0] tx_dma_channel_select,
	input wire [1:0] rx_dma_channel_select,
	input wire [2:0] dack_n,
	output wire [2:0] drq_out,
	output wire [2:0] drq_oe_n,
	output wire tx_ack,
	output wire rx_ack,
	input wire sync_routing_option,
	input wire scc_ext_sync_mode,
	output reg channel_a_sync_input_r,
	output reg receive_line_enable_bit_r,
	output reg [7:0] comm_out_r,
	output reg [7:0] cfg_out_r
);

	reg [7:0] comm_r;
	reg [7:0] comm_nxt;
	reg [7:0] cfg_r;
	reg [7:0] cfg_nxt;
	reg [7:0] rdata_nxt;
	reg rvalid_nxt;
	reg [10:0] level_onehot;
	reg [5:0] low_first;
	reg [5:0] high_first;
	reg [10:0] irq_out_nxt;
	reg [10:0] irq_oe_n_nxt;
	wire wr_comm;
	wire wr_cfg;
	wire rd_comm;
	wire rd_cfg;
	wire src_req;
	wire [1:0] src_sel;

	// Keeps only the lowest fitted jumper so two pins are never driven
	function [5:0] first_set6;
		input [5:0] v;
		integer i;
		reg done;
		begin
			first_set6 = 6'h00;
			done = 1'b0;
			for (i = 0; i < 6; i = i + 1) begin
				if (v[i] && !done) begin
					first_set6[i] = 1'b1;
					done = 1'b1;
				end
			end
		end
	endfunction

	// Card-local register decode
	function hit;
		input cs;
		input strobe;
		input [2:0] addr;
		input [2:0] ofs;
		begin
			hit = cs & strobe & (addr == ofs);
		end
	endfunction

	assign wr_comm = hit(io_cs, io_wr, io_addr, `AIRG_OFS_COMM);
	assign wr_cfg = hit(io_cs, io_wr, io_addr, `AIRG_OFS_CFG);
	assign rd_comm = hit(io_cs, io_rd, io_addr, `AIRG_OFS_COMM);
	assign rd_cfg = hit(io_cs, io_rd, io_addr, `AIRG_OFS_CFG);
	assign src_sel = {cfg_r[`AIRG_CFG_SRC_HI], cfg_r[`AIRG_CFG_SRC_LO]};

	always @* begin
		comm_nxt = comm_r;
		cfg_nxt = cfg_r;
		if (wr_comm)
			comm_nxt = io_wdata;
		if (wr_cfg)
			cfg_nxt = io_wdata;
	end

	// Offsets 0-3 belong to the serial controller and 6-7 read as zero here
	always @* begin
		rdata_nxt = 8'h00;
		rvalid_nxt = 1'b0;
		if (rd_comm) begin
			rdata_nxt = comm_r;
			rvalid_nxt = 1'b1;
		end else if (rd_cfg) begin
			rdata_nxt = cfg_r;
			rvalid_nxt = 1'b1;
		end else if (io_cs && io_rd && io_addr[2]) begin
			rvalid_nxt = 1'b1;
		end
	end

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			comm_r <= `AIRG_COMM_RST;
			cfg_r <= `AIRG_CFG_RST;
			io_rdata_r <= 8'h00;
			io_rvalid_r <= 1'b0;
			comm_out_r <= `AIRG_COMM_RST;
			cfg_out_r <= `AIRG_CFG_RST;
		end else begin
			comm_r <= comm_nxt;
			cfg_r <= cfg_nxt;
			io_rdata_r <= rdata_nxt;
			io_rvalid_r <= rvalid_nxt;
			comm_out_r <= comm_nxt;
			cfg_out_r <= cfg_nxt;
		end
	end

	// A write to the configuration register acknowledges a terminal count
	airg_irq_source u_src (
		.ref_clk(ref_clk),
		.rst(rst),
		.src_sel(src_sel),
		.irq_share_select(irq_share_select),
		.dma_tc(dma_tc),
		.scc_irq(scc_irq),
		.tc_clear(wr_cfg),
		.src_req_r(src_req)
	);

	always @* begin
		low_first = first_set6(low_irq_level_select);
		high_first = first_set6({1'b0, high_irq_level_select});
		level_onehot = {high_first[4:0], 6'h00};
		// Low group wins; a high jumper is ignored while a low one is fitted
		if (|low_irq_level_select)
			level_onehot = {5'h00, low_first};
	end

	always @* begin
		irq_out_nxt = 11'h000;
		irq_oe_n_nxt = 11'h7ff;
		if (irq_share_select) begin
			irq_out_nxt = level_onehot & {11{src_req}};
			irq_oe_n_nxt = ~(level_onehot & {11{src_req}});
		end else begin
			irq_out_nxt = level_onehot & {11{src_req}};
			irq_oe_n_nxt = ~level_onehot;
		end
	end

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			irq_out_r <= 11'h000;
			irq_oe_n_r <= 11'h7ff;
		end else begin
			irq_out_r <= irq_out_nxt;
			irq_oe_n_r <= irq_oe_n_nxt;
		end
	end

	airg_dma_route u_dma (
		.ref_clk(ref_clk),
		.rst(rst),
		.tx_dma_channel_select(tx_dma_channel_select),
		.rx_dma_channel_select(rx_dma_channel_select),
		.tx_req(tx_req),
		.rx_req(rx_req),
		.dack_n(dack_n),
		.drq_out(drq_out),
		.drq_oe_n(drq_oe_n),
		.tx_ack_r(tx_ack),
		.rx_ack_r(rx_ack)
	);

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			channel_a_sync_input_r <= 1'b0;
			receive_line_enable_bit_r <= 1'b0;
		end else begin
			channel_a_sync_input_r <= sync_routing_option & scc_ext_sync_mode &
				comm_nxt[`AIRG_COMM_RECEIVE_LINE_ENABLE_BIT];
			receive_line_enable_bit_r <= comm_nxt[`AIRG_COMM_RECEIVE_LINE_ENABLE_BIT];
		end
	end

endmodule // airg_glue

// ===== dv/airg_glue_asserts.sv
`timescale 1ns/1ps
module airg_glue_asserts (
	input wire ref_clk,
	input wire rst,
	input wire irq_share_select,
	input wire [5:0] low_irq_level_select,
	input wire [10:0] irq_out_r,
	input wire [10:0] irq_oe_n_r,
	input wire dma_tc,
	input wire scc_irq,
	input wire tx_req,
	input wire [1:0] tx_dma_channel_select,
	input wire [2:0] dack_n,
	input wire [2:0] drq_out,
	input wire [2:0] drq_oe_n,
	input wire tx_ack,
	input wire sync_routing_option,
	input wire scc_ext_sync_mode,
	input wire channel_a_sync_input_r,
	input wire receive_line_enable_bit_r,
	input wire [7:0] comm_out_r,
	input wire [7:0] cfg_out_r
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	wire sh3 = irq_share_select && low_irq_level_select == 6'h08;
	wire ns3 = !irq_share_select && low_irq_level_select == 6'h08;
	sequence s_up;
		irq_out_r[3] && !irq_oe_n_r[3];
	endsequence
	AST_SCC_UP: assert property ($rose(scc_irq) && sh3 && cfg_out_r[5:4] == 2'h3 |-> ##2 s_up)
		else $error("scc up");
	AST_SCC_DN: assert property ($fell(scc_irq) && sh3 && cfg_out_r[5:4] == 2'h3 |-> ##2 irq_oe_n_r[3])
		else $error("scc down");
	AST_TC_UP: assert property ($rose(dma_tc) && sh3 && cfg_out_r[5:4] == 2'h1 |-> ##[2:3] s_up)
		else $error("tc up");
	AST_SHARED: assert property (irq_share_select && $past(irq_share_select) |-> (irq_out_r | irq_oe_n_r) == 11'h7ff)
		else $error("shared drive");
	AST_NOSHARE: assert property (ns3 && $past(ns3) && !$past(rst) |-> !irq_oe_n_r[3])
		else $error("noshare drive");
	AST_DMA: assert property (tx_dma_channel_select == 2'h3 && $past(tx_dma_channel_select) == 2'h3 && !$past(rst)
		|-> drq_out[2] == $past(tx_req) && !drq_oe_n[2] && tx_ack == !$past(dack_n[2]))
		else $error("dma path");
	AST_SYNC: assert property (!$past(rst) |-> channel_a_sync_input_r ==
		($past(sync_routing_option && scc_ext_sync_mode) && receive_line_enable_bit_r))
		else $error("sync");
	AST_RECEIVE_LINE_ENABLE_BIT: assert property (receive_line_enable_bit_r == comm_out_r[0])
		else $error("receive_line_enable_bit");
endmodule // airg_glue_asserts
bind airg_glue airg_glue_asserts u_chk (.*);

// ===== dv/airg_host_model.sv
`timescale 1ns/1ps
module airg_host_model (
	input wire ref_clk,
	input wire [2:0] drq_out,
	input wire [2:0] drq_oe_n,
	input wire slow,
	input wire tc_go,
	output reg [2:0] dack_n,
	output reg dma_tc
);
	reg [2:0] d1;
	wire [2:0] rq = drq_out & ~drq_oe_n;
	initial begin
		dack_n = 3'h7;
		dma_tc = 1'b0;
		d1 = 3'h0;
	end
	// Slow mode acks only a request seen on two edges
	always @(posedge ref_clk) begin
		d1 <= #1 rq;
		dack_n <= #1 ~(slow ? d1 & rq : rq);
		dma_tc <= #1 tc_go;
	end
endmodule // airg_host_model

// ===== dv/airg_glue_test.sv
`timescale 1ns/1ps
module airg_glue_test;
	reg ref_clk, rst, io_cs, io_wr, io_rd, irq_share_select, scc_irq, tx_req, rx_req;
	reg sync_routing_option, scc_ext_sync_mode, slow, tc_go;
	reg [2:0] io_addr;
	reg [7:0] io_wdata;
	reg [5:0] low_irq_level_select;
	reg [4:0] high_irq_level_select;
	reg [1:0] tx_dma_channel_select, rx_dma_channel_select;
	wire [7:0] io_rdata_r, comm_out_r, cfg_out_r;
	wire [10:0] irq_out_r, irq_oe_n_r;
	wire [2:0] dack_n, drq_out, drq_oe_n;
	wire io_rvalid_r, dma_tc, tx_ack, rx_ack, channel_a_sync_input_r, receive_line_enable_bit_r;
	integer mismatches, n_checks, i;
	airg_glue dut (.*);
	airg_host_model host (.*);
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	task chk(input [47:0] nm, input [10:0] s, input [10:0] e);
		begin
			n_checks = n_checks + 1;
			if (s !== e) begin
				mismatches = mismatches + 1;
				$display("MISMATCH %0s expected %h seen %h", nm, e, s);
			end
		end
	endtask
	task cy(input integer n);
		begin
			repeat (n) @(posedge ref_clk);
			#1;
		end
	endtask
	// Trailing idle cycle keeps strobes from toggling twice in one step
	task wr(input [2:0] a, input [7:0] d);
		begin
			{io_cs, io_wr, io_addr, io_wdata} = {2'h3, a, d};
			cy(1);
			{io_cs, io_wr} = 2'h0;
			cy(1);
		end
	endtask
	task rd(input [2:0] a, input [7:0] e, input v);
		begin
			{io_cs, io_rd, io_addr} = {2'h3, a};
			cy(1);
			{io_cs, io_rd} = 2'h0;
			chk("rvalid", io_rvalid_r, v);
			if (v)
				chk("rdata", io_rdata_r, e);
			cy(1);
		end
	endtask
	// End of interrupt goes to the host controllers, outside the card window
	task eoi(input hi);
		begin
			repeat (hi ? 2 : 1) begin
				{io_wr, io_addr, io_wdata} = {1'b1, 3'h0, 8'h20};
				cy(1);
				io_wr = 1'b0;
				cy(1);
			end
		end
	endtask
	task t_regs;
		begin
			rd(3'h4, 8'h00, 1'b1);
			rd(3'h5, 8'h00, 1'b1);
			wr(3'h5, 8'ha5);
			chk("cfg", cfg_out_r, 8'ha5);
			wr(3'h6, 8'hff);
			rd(3'h5, 8'ha5, 1'b1);
			rd(3'h7, 8'h00, 1'b1);
			rd(3'h2, 8'h00, 1'b0);
			$display("test regs done");
		end
	endtask
	task t_lvl;
		begin
			wr(3'h5, 8'h20);
			for (i = 0; i < 22; i = i + 1) begin
				irq_share_select = i[0];
				{high_irq_level_select, low_irq_level_select} = 11'h001 << (i / 2);
				cy(3);
				chk("irq", irq_out_r, 11'h001 << (i / 2));
				chk("irq_oe", irq_oe_n_r, ~(11'h001 << (i / 2)));
			end
			eoi(1'b1);
			chk("irq", irq_out_r, 11'h400);
			{high_irq_level_select, low_irq_level_select} = 11'h048;
			cy(3);
			chk("irq", irq_out_r, 11'h008);
			$display("test levels done");
		end
	endtask
	task t_scc(input sh);
		begin
			irq_share_select = sh;
			wr(3'h5, 8'h30);
			scc_irq = 1'b1;
			cy(3);
			chk("irq", irq_out_r, 11'h008);
			wr(3'h3, 8'h02);
			rd(3'h3, 8'h00, 1'b0);
			wr(3'h3, 8'h38);
			chk("cfg", cfg_out_r, 8'h30);
			chk("irq", irq_out_r, 11'h008);
			scc_irq = 1'b0;
			cy(3);
			chk("irq", irq_out_r, 11'h000);
			chk("irq_oe", irq_oe_n_r, {7'h7f, sh, 3'h7});
			eoi(1'b0);
			$display("test scc done");
		end
	endtask
	task t_tc;
		begin
			irq_share_select = 1'b0;
			wr(3'h5, 8'h10);
			for (i = 0; i < 2; i = i + 1) begin
				tc_go = 1'b1;
				cy(1);
				tc_go = 1'b0;
				cy(5);
				chk("irq", irq_out_r, {7'h00, irq_share_select, 3'h0});
				irq_share_select = 1'b1;
				cy(3);
				chk("irq", irq_out_r, 11'h008);
				wr(3'h5, 8'h10);
				cy(2);
				chk("irq", irq_out_r, 11'h000);
			end
			$display("test tc done");
		end
	endtask
	task t_dma;
		begin
			{tx_dma_channel_select, rx_dma_channel_select} = 4'hd;
			{tx_req, rx_req} = 2'h3;
			cy(4);
			chk("drq", drq_out, 3'h5);
			chk("drq_oe", drq_oe_n, 3'h2);
			chk("ack", {tx_ack, rx_ack}, 2'h3);
			{rx_dma_channel_select, slow} = 3'h7;
			cy(4);
			chk("drq_oe", drq_oe_n, 3'h3);
			chk("ack", {tx_ack, rx_ack}, 2'h2);
			{tx_req, rx_req} = 2'h0;
			cy(4);
			chk("ack", {tx_ack, rx_ack}, 2'h0);
			$display("test dma done");
		end
	endtask
	task t_sync;
		begin
			{sync_routing_option, scc_ext_sync_mode} = 2'h3;
			wr(3'h4, 8'h01);
			chk("comm", comm_out_r, 8'h01);
			chk("sync", channel_a_sync_input_r, 1'b1);
			scc_ext_sync_mode = 1'b0;
			cy(2);
			chk("sync", channel_a_sync_input_r, 1'b0);
			chk("line", receive_line_enable_bit_r, 1'b1);
			wr(3'h4, 8'h00);
			chk("line", receive_line_enable_bit_r, 1'b0);
			$display("test sync done");
		end
	endtask
	task results;
		begin
			$display("checks %0d mismatches %0d", n_checks, mismatches);
			if (mismatches == 0 && n_checks > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask
	initial begin
		#50000;
		mismatches = mismatches + 1;
		results;
	end
	initial begin
		{rst, io_cs, io_wr, io_rd, irq_share_select, scc_irq, tx_req, rx_req} = 8'h80;
		{sync_routing_option, scc_ext_sync_mode, slow, tc_go, io_addr, io_wdata} = 15'h0000;
		{low_irq_level_select, high_irq_level_select} = 11'h000;
		{tx_dma_channel_select, rx_dma_channel_select} = 4'h0;
		mismatches = 0;
		n_checks = 0;
		cy(16);
		rst = 1'b0;
		t_regs;
		t_lvl;
		t_scc(1'b1);
		t_scc(1'b0);
		t_tc;
		t_dma;
		t_sync;
		results;
	end
endmodule // airg_glue_test
